// file: common/host_port_pkg.sv
// Purpose: constants and types shared by the host-port mode and configuration logic
// Assumes: byte-addressed host register port, byte registers on the low data lane
// Notes:   every offset and field position lives here, with the key and read-data reset values
// What this block does
// RULE1 - drive style: both levels, or low only
// RULE2 - dma request output polarity select
// RULE3 - dma acknowledge input polarity select
// RULE4 - dma access needs ack, optionally chip select
// RULE5 - byte order status bit reports setup
// RULE6 - status bits echo setup register write
// RULE7 - bus mode status bit reports setup
// RULE8 - init done flag reads one
// RULE9 - setup register writable only before init
// RULE10 - host writes setup after every reset
// RULE11 - either byte copy sets field
// RULE12 - byte order field selects endianness
// RULE13 - write strobe field selects strobe style
// RULE14 - interrupt polarity bit seven
// RULE15 - config writes need unlock key value
// RULE16 - setup write ends uninitialised period
package host_port_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  ADDR_UNLOCK_KEY = 8'h71;
    localparam logic [7:0]  ADDR_CONFIG     = 8'h75;
    localparam logic [7:0]  ADDR_SETUP_EVEN = 8'h7E;
    localparam logic [7:0]  ADDR_SETUP_ODD  = 8'h7F;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CFG_IRQ_POL    = 7;
    localparam int CFG_IRQ_DRIVE  = 6;
    localparam int CFG_DREQ_POL   = 5;
    localparam int CFG_DACK_POL   = 4;
    localparam int CFG_CS_QUAL    = 3;
    localparam int CFG_ENDIAN     = 2;
    localparam int CFG_BUS_MODE   = 1;
    localparam int CFG_INIT_DONE  = 0;
    localparam int SETUP_ENDIAN_H = 10;
    localparam int SETUP_ENDIAN_L = 2;
    localparam int SETUP_BUS_H    = 9;
    localparam int SETUP_BUS_L    = 1;
    localparam int LANE_LO        = 0;
    localparam int LANE_HI        = 1;

    // ************************************************************
    // reset values and keys
    // ************************************************************
    localparam logic [7:0]  UNLOCK_VALUE    = 8'h56;
    localparam logic [7:0]  KEY_RESET       = 8'h56;
    localparam logic [7:0]  READ_ZERO       = 8'h00;

    typedef enum logic [0:0] {
        ST_UNINIT = 1'b0,
        ST_READY  = 1'b1
    } port_state_t;

endpackage

// file: common/pin_pol_if.sv
`timescale 1ns/1ps
// Purpose: carries one pin's level, asserted level and polarity choice
// Assumes: single clock
// Notes:   asserted is active high inside the block
interface pin_pol_if;
    logic asserted;
    logic active_high;
    logic pin;
    modport drv_side (output asserted, output active_high, input pin);
    modport pin_to_core (input pin, input active_high, output asserted);
    modport conv_out (input asserted, input active_high, output pin);
    modport conv_in (input pin, input active_high, output asserted);
endinterface

// file: core/host_port_mode_config.sv
`timescale 1ns/1ps
// Purpose: host port setup register, configuration byte, unlock key and pin polarity
// Assumes: host register port and dma controller run on clk; pins are synchronised
// Notes:   byte registers use the low data lane; setup uses both lanes
module host_port_mode_config (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // host register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic [1:0]  reg_be,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output      logic [7:0]  reg_rdata,
    // internal requests from the device core
    input  wire logic        irq_req,
    input  wire logic        dma_req,
    // interrupt pin, tristate capable
    output      logic        irq_out_pin,
    output      logic        irq_out_pin_oe,
    // dma pins
    output      logic        dma_req_pin,
    input  wire logic        dma_ack_pin,
    input  wire logic        chip_select_pin_n,
    // mode outputs to the device core
    output      logic        dma_access_en,
    output      logic        little_endian,
    output      logic        write_strobe_style,
    output      logic        init_done
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        host_port_pkg::port_state_t st;
        logic                       endian;
        logic                       bus_mode;
        logic [7:0]                 key;
        logic                       irq_polarity;
        logic                       irq_drive_style;
        logic                       dma_req_polarity;
        logic                       dma_ack_polarity;
        logic                       cs_qualify;
        logic                       cs_s1;
        logic                       cs_s2;
        logic                       irq_oe;
        logic [7:0]                 rdata;
    } cfg_state_t;

    cfg_state_t st_r;
    cfg_state_t st_nxt;

    pin_pol_if irq_if ();
    pin_pol_if dreq_if ();
    pin_pol_if dack_if ();

    logic setup_hit;
    logic cfg_hit;
    logic key_hit;
    logic unlocked;
    logic cs_asserted;
    logic [7:0] cfg_view;

    assign setup_hit = reg_wr && (reg_addr == host_port_pkg::ADDR_SETUP_EVEN
                                  || reg_addr == host_port_pkg::ADDR_SETUP_ODD);
    assign cfg_hit   = reg_wr && reg_be[host_port_pkg::LANE_LO] && reg_addr == host_port_pkg::ADDR_CONFIG;
    assign key_hit   = reg_wr && reg_be[host_port_pkg::LANE_LO] && reg_addr == host_port_pkg::ADDR_UNLOCK_KEY;
    assign unlocked  = st_r.key == host_port_pkg::UNLOCK_VALUE;

    // readback view: status bits echo the stored setup
    always_comb begin
        cfg_view = host_port_pkg::READ_ZERO;
        cfg_view[host_port_pkg::CFG_IRQ_POL]   = st_r.irq_polarity;
        cfg_view[host_port_pkg::CFG_IRQ_DRIVE] = st_r.irq_drive_style;
        cfg_view[host_port_pkg::CFG_DREQ_POL]  = st_r.dma_req_polarity;
        cfg_view[host_port_pkg::CFG_DACK_POL]  = st_r.dma_ack_polarity;
        cfg_view[host_port_pkg::CFG_CS_QUAL]   = st_r.cs_qualify;
        cfg_view[host_port_pkg::CFG_ENDIAN]    = st_r.endian;      // [RULE5] [RULE6]
        cfg_view[host_port_pkg::CFG_BUS_MODE]  = st_r.bus_mode;    // [RULE7] [RULE6]
        cfg_view[host_port_pkg::CFG_INIT_DONE] = st_r.st == host_port_pkg::ST_READY; // [RULE8]
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt       = st_r;
        // raw pin into the first flop; nothing gates it before the second stage
        st_nxt.cs_s1 = chip_select_pin_n;
        st_nxt.cs_s2 = st_r.cs_s1;
        case (st_r.st)
            host_port_pkg::ST_UNINIT: begin
                // a late setup write would change the bus under a running host, so it locks [RULE9]
                if (setup_hit) begin
                    st_nxt.endian   = (reg_be[host_port_pkg::LANE_HI] && reg_wdata[host_port_pkg::SETUP_ENDIAN_H])
                                   || (reg_be[host_port_pkg::LANE_LO] && reg_wdata[host_port_pkg::SETUP_ENDIAN_L]); // [RULE11] [RULE12]
                    st_nxt.bus_mode = (reg_be[host_port_pkg::LANE_HI] && reg_wdata[host_port_pkg::SETUP_BUS_H])
                                   || (reg_be[host_port_pkg::LANE_LO] && reg_wdata[host_port_pkg::SETUP_BUS_L]);    // [RULE11] [RULE13]
                    st_nxt.st       = host_port_pkg::ST_READY; // [RULE16]
                end
            end
            host_port_pkg::ST_READY: begin
                st_nxt.st = host_port_pkg::ST_READY;
            end
            default: begin
                st_nxt.st = host_port_pkg::ST_UNINIT;
            end
        endcase
        if (key_hit) begin
            st_nxt.key = reg_wdata[7:0];
        end
        if (cfg_hit && unlocked) begin // [RULE15]
            st_nxt.irq_polarity     = reg_wdata[host_port_pkg::CFG_IRQ_POL];   // [RULE14]
            st_nxt.irq_drive_style  = reg_wdata[host_port_pkg::CFG_IRQ_DRIVE]; // [RULE1]
            st_nxt.dma_req_polarity = reg_wdata[host_port_pkg::CFG_DREQ_POL];  // [RULE2]
            st_nxt.dma_ack_polarity = reg_wdata[host_port_pkg::CFG_DACK_POL];  // [RULE3]
            st_nxt.cs_qualify       = reg_wdata[host_port_pkg::CFG_CS_QUAL];   // [RULE4]
        end
        // open-drain style only enables the driver while asserted [RULE1]
        st_nxt.irq_oe = st_r.irq_drive_style ? irq_req : 1'b1;
        if (reg_rd) begin
            if (reg_addr == host_port_pkg::ADDR_CONFIG) begin
                st_nxt.rdata = cfg_view;
            end else if (reg_addr == host_port_pkg::ADDR_UNLOCK_KEY) begin
                st_nxt.rdata = st_r.key;
            end else begin
                st_nxt.rdata = host_port_pkg::READ_ZERO;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r                  <= '0;
            st_r.st               <= host_port_pkg::ST_UNINIT;
            st_r.key              <= host_port_pkg::KEY_RESET;
            st_r.irq_oe           <= 1'b1;
            // released select idles high, so no false select right after reset
            st_r.cs_s1            <= 1'b1;
            st_r.cs_s2            <= 1'b1;
            st_r.rdata            <= host_port_pkg::READ_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // pins
    // ************************************************************
    assign irq_if.asserted     = irq_req;
    assign irq_if.active_high  = st_r.irq_polarity;
    assign dreq_if.asserted    = dma_req;
    assign dreq_if.active_high = st_r.dma_req_polarity;
    assign dack_if.pin         = dma_ack_pin;
    assign dack_if.active_high = st_r.dma_ack_polarity;

    pin_polarity #(.IS_INPUT(1'b0)) u_irq_pol (
        .clk         (clk),
        .nrst        (nrst),
        .src_level   (irq_if.asserted),
        .active_high (irq_if.active_high),
        .dst_level   (irq_if.pin)
    );

    pin_polarity #(.IS_INPUT(1'b0)) u_dreq_pol (
        .clk         (clk),
        .nrst        (nrst),
        .src_level   (dreq_if.asserted),
        .active_high (dreq_if.active_high),
        .dst_level   (dreq_if.pin)
    );

    pin_polarity #(.IS_INPUT(1'b1)) u_dack_pol (
        .clk         (clk),
        .nrst        (nrst),
        .src_level   (dack_if.pin),
        .active_high (dack_if.active_high),
        .dst_level   (dack_if.asserted)
    );

    assign cs_asserted        = ~st_r.cs_s2;
    assign irq_out_pin        = st_r.irq_drive_style ? 1'b0 : irq_if.pin;  // [RULE1] [RULE14]
    assign irq_out_pin_oe     = st_r.irq_oe;                               // [RULE1]
    assign dma_req_pin        = dreq_if.pin;                               // [RULE2]
    assign dma_access_en      = st_r.cs_qualify ? (dack_if.asserted && cs_asserted)
                                                : dack_if.asserted;        // [RULE3] [RULE4]
    assign little_endian      = st_r.endian;
    assign write_strobe_style = st_r.bus_mode;
    assign init_done          = st_r.st == host_port_pkg::ST_READY;        // [RULE8]
    assign reg_rdata          = st_r.rdata;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_setup_first;
        !init_done && setup_hit;
    endsequence

    sequence s_ack_held;
        $stable(dma_ack_pin) && $stable(st_r.dma_ack_polarity) [*4];
    endsequence

    a_setup_locked: assert property ( // [RULE9]
            init_done && setup_hit |=> $stable(st_r.endian) && $stable(st_r.bus_mode))
        else $error("setup changed after init");
    a_setup_merge: assert property ( // [RULE11]
            s_setup_first |=> little_endian ==
            $past((reg_be[host_port_pkg::LANE_HI] && reg_wdata[host_port_pkg::SETUP_ENDIAN_H])
                  || (reg_be[host_port_pkg::LANE_LO] && reg_wdata[host_port_pkg::SETUP_ENDIAN_L])))
        else $error("endian merge wrong");
    a_bus_merge: assert property ( // [RULE13]
            s_setup_first |=> write_strobe_style ==
            $past((reg_be[host_port_pkg::LANE_HI] && reg_wdata[host_port_pkg::SETUP_BUS_H])
                  || (reg_be[host_port_pkg::LANE_LO] && reg_wdata[host_port_pkg::SETUP_BUS_L])))
        else $error("bus mode merge wrong");
    a_init_set: assert property (s_setup_first |=> init_done ##1 init_done) // [RULE16]
        else $error("init flag not set");
    a_init_cause: assert property ($rose(init_done) |-> $past(setup_hit)) // [RULE8]
        else $error("init flag rose without setup");
    a_cfg_locked: assert property ( // [RULE15]
            cfg_hit && !unlocked |=> $stable(st_r.irq_polarity) && $stable(st_r.cs_qualify))
        else $error("config written while locked");
    a_cfg_open: assert property ( // [RULE15]
            cfg_hit && unlocked |=> st_r.cs_qualify == $past(reg_wdata[host_port_pkg::CFG_CS_QUAL])
            && st_r.irq_polarity == $past(reg_wdata[host_port_pkg::CFG_IRQ_POL]))
        else $error("config write lost");
    a_status_echo: assert property ( // [RULE6]
            reg_rd && reg_addr == host_port_pkg::ADDR_CONFIG |=>
            reg_rdata[host_port_pkg::CFG_ENDIAN] == little_endian
            && reg_rdata[host_port_pkg::CFG_BUS_MODE] == write_strobe_style
            && reg_rdata[host_port_pkg::CFG_INIT_DONE] == init_done)
        else $error("status bits do not echo setup");
    a_irq_hiz: assert property ( // [RULE1]
            st_r.irq_drive_style && $stable(st_r.irq_drive_style) |->
            !irq_out_pin && irq_out_pin_oe == $past(irq_req))
        else $error("interrupt open drain wrong");
    // the pin flop still holds its reset level at the first edge after release
    a_irq_level: assert property ( // [RULE14]
            $past(nrst) && !st_r.irq_drive_style && $stable(st_r.irq_drive_style)
            && $stable(st_r.irq_polarity) |->
            irq_out_pin_oe && irq_out_pin == (st_r.irq_polarity ? $past(irq_req) : !$past(irq_req)))
        else $error("interrupt level wrong");
    a_ack_level: assert property ( // [RULE3]
            s_ack_held |-> dack_if.asserted == (dma_ack_pin == st_r.dma_ack_polarity))
        else $error("ack polarity wrong");
    a_cs_qualify: assert property (st_r.cs_qualify && !cs_asserted |-> !dma_access_en) // [RULE4]
        else $error("dma access without chip select");
endmodule // host_port_mode_config

// file: core/pin_polarity.sv
`timescale 1ns/1ps
// Purpose: polarity conversion between an asserted-high level and a pin level
// Assumes: IS_INPUT=1 means the pin arrives from outside and is synchronised
// Notes:   output path has one cycle latency, input path three
module pin_polarity #(
    parameter bit IS_INPUT = 1'b0
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // converted signal
    input  wire logic src_level,
    input  wire logic active_high,
    output      logic dst_level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic out;
        logic [1:0] fill;
    } pol_state_t;

    pol_state_t st_r;
    pol_state_t st_nxt;

    always_comb begin
        logic sampled;
        sampled       = IS_INPUT ? st_r.s2 : src_level;
        st_nxt        = st_r;
        st_nxt.s1     = src_level;
        st_nxt.s2     = st_r.s1;
        st_nxt.fill   = {st_r.fill[0], 1'b1};
        // same xnor serves both directions; an input stays deasserted until its
        // synchroniser holds a real pin level, else reset zeros read as asserted low
        st_nxt.out    = (IS_INPUT && !st_r.fill[1]) ? 1'b0 : (active_high ? sampled : ~sampled);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dst_level = st_r.out;

    a_pol_map: assert property (@(posedge clk) disable iff (!nrst) // [RULE2]
        $past(nrst, 3) && $stable(active_high) |->
            dst_level == (active_high ? $past(IS_INPUT ? st_r.s2 : src_level)
                                      : !$past(IS_INPUT ? st_r.s2 : src_level)))
        else $error("pin polarity mapping wrong");
endmodule // pin_polarity

// file: test/host_dma_model.sv
// Purpose: host cpu and dma controller pins as seen by the host port
// Assumes: the host follows the polarity that it has programmed into the configuration byte
// Notes:   behavioural; the bench drives the requests just after a clock edge
`timescale 1ns/1ps
module host_dma_model (
    // requests from the bench
    input  wire logic ack_req,
    input  wire logic cs_req,
    input  wire logic ack_active_high,
    // pins towards the device
    output      logic dma_ack_pin,
    output      logic chip_select_pin_n
);
    // the acknowledge pin follows the level that the device is set to treat as asserted
    assign dma_ack_pin       = ack_active_high ? ack_req : ~ack_req;
    // chip select is driven on request, so qualified dma can be both enabled and refused
    assign chip_select_pin_n = ~cs_req;
endmodule // host_dma_model

// file: test/host_port_mode_config_tb.sv
// Purpose: self-checking bench for the host port setup and configuration logic
// Assumes: register reads are scored from a queue one cycle after the read strobe
// Notes:   pin levels are checked after the input synchronisers have settled
`timescale 1ns/1ps
module host_port_mode_config_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [1:0]  reg_be = 2'b00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        irq_req = 1'b0;
    logic        dma_req = 1'b0;
    logic        ack_req = 1'b0;
    logic        cs_req = 1'b0;
    logic        irq_out_pin;
    logic        irq_out_pin_oe;
    logic        dma_req_pin;
    logic        dma_ack_pin;
    logic        chip_select_pin_n;
    logic        dma_access_en;
    logic        little_endian;
    logic        write_strobe_style;
    logic        init_done;
    logic [7:0]  cfg = 8'h00;
    logic [7:0]  exp_q[$];
    logic        rd_d = 1'b0;
    logic        e;
    logic        b;
    logic        exp_oe;
    logic [31:0] r;
    int          seed = 32'h2DE5;
    int          bad_count = 0;
    int          tests_run = 0;

    always #2 clk = ~clk;

    host_port_mode_config DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_be(reg_be), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req),
        .dma_req(dma_req), .irq_out_pin(irq_out_pin), .irq_out_pin_oe(irq_out_pin_oe),
        .dma_req_pin(dma_req_pin), .dma_ack_pin(dma_ack_pin), .chip_select_pin_n(chip_select_pin_n),
        .dma_access_en(dma_access_en), .little_endian(little_endian),
        .write_strobe_style(write_strobe_style), .init_done(init_done));

    host_dma_model host (.ack_req(ack_req), .cs_req(cs_req), .ack_active_high(cfg[host_port_pkg::CFG_DACK_POL]),
        .dma_ack_pin(dma_ack_pin), .chip_select_pin_n(chip_select_pin_n));

    // ************************************************************
    // compare, report and bus tasks
    // ************************************************************
    task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic summarize();
        $display("mismatches %0d of %0d comparisons", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_be    = be;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        exp_q.push_back(exp);
        @(posedge clk);
        #1;
        reg_rd   = 1'b0;
    endtask

    task automatic apply_reset();
        nrst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
    endtask

    // ************************************************************
    // read scoreboard: data stands in the cycle after the strobe
    // ************************************************************
    always @(posedge clk) rd_d <= reg_rd & nrst;

    always @(negedge clk) begin
        if (rd_d) begin
            cmp_byte("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    initial begin
        #40000;
        bad_count++;
        summarize();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        for (int i = 0; i < 4; i++) begin
            apply_reset();
            e = i[1];
            // each lane sees each field value once across the four passes
            b = i[0] ~^ i[1];
            cmp_bit("init_done", 1'b0, init_done);
            reg_read(host_port_pkg::ADDR_CONFIG, 8'h00);
            reg_read(host_port_pkg::ADDR_UNLOCK_KEY, host_port_pkg::KEY_RESET);
            reg_read(8'h10, host_port_pkg::READ_ZERO);
            // setup first after every reset, one lane at a time so each copy is proven alone;
            // the disabled lane carries ones, so a write that ignored the byte enables shows up
            reg_write(i[0] ? host_port_pkg::ADDR_SETUP_ODD : host_port_pkg::ADDR_SETUP_EVEN,
                      i[0] ? {5'h00, e, b, 9'h006} : {5'h00, 2'b11, 6'h00, e, b, 1'b0},
                      i[0] ? 2'b10 : 2'b01);
            cmp_bit("init_done", 1'b1, init_done);
            cmp_bit("little_endian", e, little_endian);
            cmp_bit("write_strobe_style", b, write_strobe_style);
            reg_read(host_port_pkg::ADDR_CONFIG, {5'h00, e, b, 1'b1});
            reg_write(host_port_pkg::ADDR_SETUP_EVEN, {~{5'h00, e, b, 6'h00, e, b}, 1'b0}, 2'b11);
            cmp_bit("little_endian", e, little_endian);
            cmp_bit("write_strobe_style", b, write_strobe_style);
        end
        // open write lands, then a locked write must leave it alone
        reg_write(host_port_pkg::ADDR_CONFIG, 16'h00F8, 2'b01);
        reg_read(host_port_pkg::ADDR_CONFIG, 8'hFF);
        reg_write(host_port_pkg::ADDR_UNLOCK_KEY, 16'h0000, 2'b01);
        reg_write(host_port_pkg::ADDR_CONFIG, 16'h0000, 2'b01);
        reg_read(host_port_pkg::ADDR_CONFIG, 8'hFF);
        reg_read(host_port_pkg::ADDR_UNLOCK_KEY, 8'h00);
        reg_write(host_port_pkg::ADDR_UNLOCK_KEY, {8'h00, host_port_pkg::UNLOCK_VALUE}, 2'b01);
        // every combination of the writable bits, with random pin requests
        for (int c = 0; c < 32; c++) begin
            cfg = {c[4:0], 3'b000};
            reg_write(host_port_pkg::ADDR_CONFIG, {8'h00, cfg}, 2'b01);
            r = $random(seed);
            irq_req = r[0];
            dma_req = r[1];
            ack_req = r[2];
            cs_req  = r[3];
            repeat (5) @(posedge clk);
            #1;
            exp_oe = cfg[host_port_pkg::CFG_IRQ_DRIVE] ? irq_req : 1'b1;
            cmp_bit("irq_out_pin_oe", exp_oe, irq_out_pin_oe);
            if (exp_oe) begin
                cmp_bit("irq_out_pin", cfg[host_port_pkg::CFG_IRQ_DRIVE] ? 1'b0 :
                        irq_req ~^ cfg[host_port_pkg::CFG_IRQ_POL], irq_out_pin);
            end
            cmp_bit("dma_req_pin", dma_req ~^ cfg[host_port_pkg::CFG_DREQ_POL], dma_req_pin);
            cmp_bit("dma_access_en", ack_req & (~cfg[host_port_pkg::CFG_CS_QUAL] | cs_req),
                    dma_access_en);
            reg_read(host_port_pkg::ADDR_CONFIG, {cfg[7:3], 3'b111});
        end
        repeat (3) @(posedge clk);
        summarize();
    end
endmodule // host_port_mode_config_tb
